// File: rtl/ioc_pkg.sv
// constants, types and config layout for the pin i/o cell
// assumes one 40 mhz system clock; pin clocks arrive as sampled levels
//
// How it works
// - pin reaches fabric directly or via register
// - input register is flop or latch
// - global line and power-up load chosen init value
// - flop captures on rising edge when enabled
// - latch transparent high, flop rising edge
// - enable low holds; tie high if unused
// - inverted clock gives falling/transparent-low forms
// - input delay full, partial, none, or skipped
// - fabric outputs each pick direct or registered
// - capture latch runs on output clock
// - capture latch feeds flop or latch
// - capture chain clocks invertible inside cell
// - output optionally inverted, then direct or flop
// - output flop loads when enabled, floats high
// - shared enable applies to input, output, both
// - no user set/reset, only global one
package ioc_pkg;

   // ***********************************
   // bus map
   // ***********************************
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] CFG_OFS = 4'h0;
   localparam logic [ADR_W-1:0] STS_OFS = 4'h4;

   // ***********************************
   // delay element
   // ***********************************
   typedef enum logic [1:0] {DLY_FULL, DLY_PART, DLY_NONE} ioc_dly_t;
   localparam int DLY_FULL_TAPS = 2; // cycles of the full delay
   localparam int DLY_PART_TAPS = 1; // cycles of the partial delay

   // ***********************************
   // configuration word, 16 bits
   // ***********************************
   typedef struct packed {
      logic out_init_set;
      logic in_init_set;
      logic en_out;
      logic en_in;
      logic out_clk_inv;
      logic out_reg;
      logic out_inv;
      logic cap_clk_inv;
      logic cap_en;
      logic skip_dly;
      ioc_dly_t dly;
      logic in_route_b;
      logic in_route_a;
      logic in_clk_inv;
      logic in_latch;
   } ioc_cfg_t;

   localparam int CFG_W = $bits(ioc_cfg_t);
   localparam ioc_cfg_t CFG_RST = '{
      out_init_set: 1'b0, in_init_set: 1'b0, en_out: 1'b1, en_in: 1'b1,
      out_clk_inv: 1'b0, out_reg: 1'b0, out_inv: 1'b0, cap_clk_inv: 1'b0,
      cap_en: 1'b0, skip_dly: 1'b0, dly: DLY_FULL, in_route_b: 1'b0,
      in_route_a: 1'b0, in_clk_inv: 1'b0, in_latch: 1'b0};

   // ***********************************
   // status bit positions
   // ***********************************
   localparam int STS_PAD_BIT = 0;
   localparam int STS_IN_BIT = 1;
   localparam int STS_CAP_BIT = 2;
   localparam int STS_OUT_BIT = 3;
   localparam int STS_GLB_BIT = 4;
   localparam int STS_OEN_BIT = 5;

endpackage

// File: rtl/ioc_store.sv
// one storage element of the cell: edge flop or level latch
// assumes its clock arrives as a level sampled on clk_i
module ioc_store (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic glob_i,
   input wire logic init_set_i,
   input wire logic latch_mode_i,
   input wire logic clk_lvl_i,
   input wire logic en_i,
   input wire logic d_i,
   output logic q_o,
   output logic state_o
);
   logic q_q;
   logic clk_prev_q;

   // previous clock level for edge detection; tracks the pin through reset
   // so a clock parked high cannot fake an edge right after release
   always_ff @(posedge clk_i) begin
      clk_prev_q <= clk_lvl_i;
   end

   // only the global line or power-up initialises
   always_ff @(posedge clk_i) begin
      if (rst_i || glob_i) begin
         q_q <= init_set_i;
      end else if (en_i) begin // enable low holds
         if (latch_mode_i) begin
            if (clk_lvl_i) begin // transparent while clock high
               q_q <= d_i;
            end
         end else if (clk_lvl_i && !clk_prev_q) begin // rising edge
            q_q <= d_i;
         end
      end
   end

   // open latch passes data straight through
   assign q_o = (latch_mode_i && clk_lvl_i && en_i && !glob_i) ? d_i : q_q;
   assign state_o = q_q;

endmodule

// File: rtl/ioc_top.sv
// pin i/o cell: input delay, input register, fast capture latch,
// output inversion, output flop and three-state control
// assumes a wishbone classic master and pin clocks synchronous to clk_i
//
// Our own choices: register access over Wishbone and the placing of the registers.
module ioc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ioc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pad_i,
   output logic pad_o,
   output logic pad_oe_n_o,
   input wire logic global_set_reset_i,
   input wire logic capture_enable_line_i,
   input wire logic input_register_clock_i,
   input wire logic output_register_clock_i,
   input wire logic output_float_control_i,
   input wire logic fabric_output_i,
   output logic fabric_input_a_o,
   output logic fabric_input_b_o
);

   // ***********************************
   // declarations
   // ***********************************
   ioc_pkg::ioc_cfg_t cfg_q;
   ioc_pkg::ioc_cfg_t cfg_d;
   logic ack_q;
   logic [31:0] dat_q;
   logic [ioc_pkg::DLY_FULL_TAPS-1:0] dly_q;
   logic din;
   logic in_clk_lvl;
   logic cap_clk_lvl;
   logic out_clk_lvl;
   logic in_en;
   logic out_en;
   logic cap_q;
   logic cap_state;
   logic in_d;
   logic in_q;
   logic in_state;
   logic obit;
   logic out_state;
   logic bus_req;
   logic cfg_wr;
   logic [31:0] cfg_word;
   logic [31:0] rd_word;

   // ***********************************
   // wishbone slave
   // ***********************************
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign cfg_wr = bus_req && wb_we_i && (wb_adr_i == ioc_pkg::CFG_OFS);

   // one-cycle ack, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // byte lanes merged into the current config
   always_comb begin
      cfg_word = 32'(cfg_q);
      for (int i = 0; i < 4; i++) begin
         if (wb_sel_i[i]) begin
            cfg_word[i*8 +: 8] = wb_dat_i[i*8 +: 8];
         end
      end
      cfg_d = ioc_pkg::ioc_cfg_t'(cfg_word[ioc_pkg::CFG_W-1:0]);
   end

   // writes land only while the global line holds the cell in init,
   // so routing never changes under live data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= ioc_pkg::CFG_RST;
      end else if (cfg_wr && global_set_reset_i) begin
         cfg_q <= cfg_d;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (wb_adr_i)
         ioc_pkg::CFG_OFS: rd_word = 32'(cfg_q);
         ioc_pkg::STS_OFS: begin
            rd_word[ioc_pkg::STS_PAD_BIT] = pad_i;
            rd_word[ioc_pkg::STS_IN_BIT] = in_state;
            rd_word[ioc_pkg::STS_CAP_BIT] = cap_state;
            rd_word[ioc_pkg::STS_OUT_BIT] = out_state;
            rd_word[ioc_pkg::STS_GLB_BIT] = global_set_reset_i;
            rd_word[ioc_pkg::STS_OEN_BIT] = pad_oe_n_o;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // read data registered alongside ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         dat_q <= rd_word;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ***********************************
   // input delay
   // ***********************************
   // tap chain; data path, needs no reset
   always_ff @(posedge clk_i) begin
      dly_q <= {dly_q[ioc_pkg::DLY_FULL_TAPS-2:0], pad_i};
   end

   // skip attribute wins over the tap choice
   always_comb begin
      if (cfg_q.skip_dly || cfg_q.dly == ioc_pkg::DLY_NONE) begin
         din = pad_i;
      end else if (cfg_q.dly == ioc_pkg::DLY_PART) begin
         din = dly_q[ioc_pkg::DLY_PART_TAPS-1];
      end else begin
         din = dly_q[ioc_pkg::DLY_FULL_TAPS-1];
      end
   end

   // ***********************************
   // clocks and enables
   // ***********************************
   // per-element polarity, absorbed in the cell
   assign in_clk_lvl = input_register_clock_i ^ cfg_q.in_clk_inv;
   assign cap_clk_lvl = !(output_register_clock_i ^ cfg_q.cap_clk_inv);
   assign out_clk_lvl = output_register_clock_i ^ cfg_q.out_clk_inv;
   // shared enable steered per side
   assign in_en = cfg_q.en_in ? capture_enable_line_i : 1'b1;
   assign out_en = (cfg_q.en_out ? capture_enable_line_i : 1'b1) && !output_float_control_i;

   // ***********************************
   // input path
   // ***********************************
   // fast capture latch, transparent-low on the output clock
   ioc_store u_cap (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .glob_i(global_set_reset_i),
      .init_set_i(cfg_q.in_init_set),
      .latch_mode_i(1'b1),
      .clk_lvl_i(cap_clk_lvl),
      .en_i(in_en),
      .d_i(din),
      .q_o(cap_q),
      .state_o(cap_state)
   );

   assign in_d = cfg_q.cap_en ? cap_q : din;

   // main input register, flop or latch by config
   ioc_store u_in (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .glob_i(global_set_reset_i),
      .init_set_i(cfg_q.in_init_set),
      .latch_mode_i(cfg_q.in_latch),
      .clk_lvl_i(in_clk_lvl),
      .en_i(in_en),
      .d_i(in_d),
      .q_o(in_q),
      .state_o(in_state)
   );

   // each fabric output picks direct pin or register
   assign fabric_input_a_o = cfg_q.in_route_a ? in_q : pad_i;
   assign fabric_input_b_o = cfg_q.in_route_b ? in_q : pad_i;

   // ***********************************
   // output path
   // ***********************************
   assign obit = fabric_output_i ^ cfg_q.out_inv;

   // output flop loads only while enabled and not floating
   ioc_store u_out (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .glob_i(global_set_reset_i),
      .init_set_i(cfg_q.out_init_set),
      .latch_mode_i(1'b0),
      .clk_lvl_i(out_clk_lvl),
      .en_i(out_en),
      .d_i(obit),
      .q_o(),
      .state_o(out_state)
   );

   // direct or registered drive; float high releases the pin
   assign pad_o = cfg_q.out_reg ? out_state : obit;
   assign pad_oe_n_o = output_float_control_i;

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic in_clk_prev;
   logic out_clk_prev;
   always_ff @(posedge clk_i) begin
      in_clk_prev <= in_clk_lvl;
      out_clk_prev <= out_clk_lvl;
   end

   property p_glob_init;
      global_set_reset_i |=> (in_state == $past(cfg_q.in_init_set))
         && (out_state == $past(cfg_q.out_init_set));
   endproperty
   a_glob_init: assert property (p_glob_init) else $error("init value not loaded");

   property p_in_flop_capture;
      (!cfg_q.in_latch && in_clk_lvl && !in_clk_prev && in_en && !global_set_reset_i)
         |=> in_state == $past(in_d);
   endproperty
   a_in_flop_capture: assert property (p_in_flop_capture) else $error("flop missed edge");

   property p_in_hold;
      (!in_en && !global_set_reset_i) |=> $stable(in_state);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("input reg changed while disabled");

   property p_in_latch_pass;
      (cfg_q.in_latch && in_clk_lvl && in_en && !global_set_reset_i) |-> in_q == in_d;
   endproperty
   a_in_latch_pass: assert property (p_in_latch_pass) else $error("latch not transparent");

   property p_route_a;
      cfg_q.in_route_a |-> fabric_input_a_o == in_q;
   endproperty
   a_route_a: assert property (p_route_a) else $error("route a wrong");

   property p_delay_full;
      (cfg_q.dly == ioc_pkg::DLY_FULL && !cfg_q.skip_dly && $stable(cfg_q))
         |-> din == $past(pad_i, 2);
   endproperty
   a_delay_full: assert property (p_delay_full) else $error("full delay wrong");

   property p_out_load;
      (cfg_q.out_reg && out_clk_lvl && !out_clk_prev && out_en && !global_set_reset_i)
         |=> pad_o == $past(obit);
   endproperty
   a_out_load: assert property (p_out_load) else $error("output flop missed load");

   property p_out_float;
      output_float_control_i && !global_set_reset_i |=> $stable(out_state);
   endproperty
   a_out_float: assert property (p_out_float) else $error("flop moved while floating");

   property p_cfg_lock;
      (cfg_wr && !global_set_reset_i) |=> $stable(cfg_q);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("config changed in operation");

   property p_ack_once;
      ack_q |=> !ack_q;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

   property p_route_b;
      cfg_q.in_route_b |-> fabric_input_b_o == in_q;
   endproperty
   a_route_b: assert property (p_route_b) else $error("route b wrong");

   property p_direct_a;
      !cfg_q.in_route_a |-> fabric_input_a_o == pad_i;
   endproperty
   a_direct_a: assert property (p_direct_a) else $error("direct path a wrong");

   property p_skip_dly;
      cfg_q.skip_dly |-> din == pad_i;
   endproperty
   a_skip_dly: assert property (p_skip_dly) else $error("skipped delay still delays");

   property p_dly_part;
      (cfg_q.dly == ioc_pkg::DLY_PART && !cfg_q.skip_dly) |-> din == $past(pad_i);
   endproperty
   a_dly_part: assert property (p_dly_part) else $error("partial delay wrong");

   property p_in_latch_hold;
      (cfg_q.in_latch && !in_clk_lvl && !global_set_reset_i) |=> $stable(in_state);
   endproperty
   a_in_latch_hold: assert property (p_in_latch_hold) else $error("closed latch moved");

   property p_in_flop_idle;
      (!cfg_q.in_latch && !(in_clk_lvl && !in_clk_prev) && !global_set_reset_i)
         |=> $stable(in_state);
   endproperty
   a_in_flop_idle: assert property (p_in_flop_idle) else $error("flop moved off edge");

   property p_in_fall;
      (!cfg_q.in_latch && cfg_q.in_clk_inv && !input_register_clock_i && !in_clk_prev
         && in_en && !global_set_reset_i) |=> in_state == $past(in_d);
   endproperty
   a_in_fall: assert property (p_in_fall) else $error("falling edge missed");

   property p_cap_pass;
      ((output_register_clock_i == cfg_q.cap_clk_inv) && in_en && !global_set_reset_i)
         |-> cap_q == din;
   endproperty
   a_cap_pass: assert property (p_cap_pass) else $error("capture latch not open");

   property p_cap_hold;
      ((output_register_clock_i != cfg_q.cap_clk_inv) && !global_set_reset_i)
         |=> $stable(cap_state);
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("capture latch leaked");

   property p_out_direct;
      !cfg_q.out_reg |-> pad_o == (fabric_output_i ^ cfg_q.out_inv);
   endproperty
   a_out_direct: assert property (p_out_direct) else $error("direct output wrong");

   property p_float_pin;
      output_float_control_i |-> pad_oe_n_o;
   endproperty
   a_float_pin: assert property (p_float_pin) else $error("pin driven while floating");

   property p_drive_pin;
      !output_float_control_i |-> !pad_oe_n_o;
   endproperty
   a_drive_pin: assert property (p_drive_pin) else $error("pin released while driving");

   property p_out_en_hold;
      (cfg_q.en_out && !capture_enable_line_i && !global_set_reset_i) |=> $stable(out_state);
   endproperty
   a_out_en_hold: assert property (p_out_en_hold) else $error("output flop ignored enable");

   property p_out_en_free;
      (!cfg_q.en_out && out_clk_lvl && !out_clk_prev && !output_float_control_i
         && !global_set_reset_i) |=> out_state == $past(obit);
   endproperty
   a_out_en_free: assert property (p_out_en_free) else $error("output flop gated");

   c_cap_chain: cover property (cfg_q.cap_en && cfg_q.in_latch && in_clk_lvl);
   c_out_reg: cover property (cfg_q.out_reg && out_clk_lvl && !out_clk_prev && out_en);
   c_float: cover property (output_float_control_i ##1 !output_float_control_i);
   c_in_fall: cover property (cfg_q.in_clk_inv && !cfg_q.in_latch && in_clk_lvl && !in_clk_prev);
   c_cfg_write: cover property (cfg_wr && global_set_reset_i);

endmodule

// File: verification/ioc_pin_model.sv
// far-side device on the package pin of the i/o cell
// assumes the cell reports float by pad_oe_n high
module ioc_pin_model (
   input wire logic ext_i,
   input wire logic pad_o_i,
   input wire logic oe_n_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire level: the cell owns the pin unless floated
   assign pin_o = oe_n_i ? ext_i : pad_o_i;
endmodule

// File: verification/tb.sv
// self-checking bench for the pin i/o cell with a reference model
// assumes ioc_pkg, ioc_top and the pin model are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // stimulus and wires
   // ****************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, glob = 1'b0, cen = 1'b1, ext = 1'b0;
   logic ick = 1'b0, ock = 1'b0, flt = 1'b1, fo = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic ack, pin, pad_out, oe_n, fa, fb;
   logic [16:0] lfsr = 17'h16140;
   int mismatches = 0, cmp_count = 0;
   ioc_pkg::ioc_cfg_t c = ioc_pkg::CFG_RST;
   // free-running system clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   ioc_top i_ioc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pad_i(pin), .pad_o(pad_out), .pad_oe_n_o(oe_n),
      .global_set_reset_i(glob), .capture_enable_line_i(cen), .input_register_clock_i(ick),
      .output_register_clock_i(ock), .output_float_control_i(flt), .fabric_output_i(fo),
      .fabric_input_a_o(fa), .fabric_input_b_o(fb));
   ioc_pin_model i_ioc_pin_model (.ext_i(ext), .pad_o_i(pad_out), .oe_n_i(oe_n), .pin_o(pin));
   // ****************
   // reference model
   // ****************
   logic [1:0] h_q = 2'h0;
   logic pk_q = 1'b0, po_q = 1'b0, mq_q, cq_q, oq_q;
   logic dq, ck, en, co, di, ea, ob, okc;
   int tp;
   // delay taps, clock polarity, enables and the capture chain
   assign tp = c.skip_dly ? 0 : c.dly == ioc_pkg::DLY_FULL ? ioc_pkg::DLY_FULL_TAPS
      : c.dly == ioc_pkg::DLY_PART ? ioc_pkg::DLY_PART_TAPS : 0;
   assign dq = tp == 0 ? pin : tp == 1 ? h_q[0] : h_q[1];
   assign ck = ick ^ c.in_clk_inv;
   assign en = cen | ~c.en_in;
   assign co = (~(ock ^ c.cap_clk_inv) & en) ? dq : cq_q;
   assign di = c.cap_en ? co : dq;
   assign ea = (c.in_latch & ck & en) ? di : mq_q;
   assign ob = fo ^ c.out_inv;
   assign okc = ock ^ c.out_clk_inv;
   // storage; reset and the global line both load the chosen init value
   always @(posedge clk_i) begin
      h_q <= {h_q[0], pin};
      pk_q <= ck;
      po_q <= okc;
      if (rst_i | glob) begin
         mq_q <= c.in_init_set;
         cq_q <= c.in_init_set;
         oq_q <= c.out_init_set;
      end else begin
         if (en & ck & (c.in_latch | ~pk_q)) mq_q <= di;
         if (en & ~(ock ^ c.cap_clk_inv)) cq_q <= dq;
         if ((cen | ~c.en_out) & okc & ~po_q & ~flt) oq_q <= ob;
      end
   end
   // ****************
   // tasks
   // ****************
   function automatic logic [16:0] nxt(input logic [16:0] v);
      repeat (17) v = {v[15:0], v[16] ^ v[13]};
      return v;
   endfunction
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; the request stays put until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 16);
      rd = rdat;
      if (ack !== 1'b1) begin
         mismatches++;
         close_out();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk("read", e, rd);
   endtask
   // config only lands under the global line; pin clocks parked at their inversion bits so the register clock levels read low meanwhile
   task automatic setc(input ioc_pkg::ioc_cfg_t v);
      ick <= v.in_clk_inv;
      ock <= v.out_clk_inv;
      glob <= 1'b1;
      c <= v;
      wb(1'b1, ioc_pkg::CFG_OFS, {16'h0, v});
      glob <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      ioc_pkg::ioc_cfg_t v;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(ioc_pkg::CFG_OFS, {16'h0, ioc_pkg::CFG_RST});
      wb(1'b1, ioc_pkg::CFG_OFS, 32'hffff);
      rchk(ioc_pkg::CFG_OFS, {16'h0, ioc_pkg::CFG_RST});
      wb(1'b1, ioc_pkg::STS_OFS, 32'hffffffff);
      rchk(ioc_pkg::STS_OFS, 32'h20);
      rchk(4'h8, 32'h0);
      // random static configs, then random pin traffic against the model
      for (int p = 0; p < 16; p++) begin
         lfsr = nxt(lfsr);
         v = ioc_pkg::ioc_cfg_t'(lfsr[15:0]);
         if (v.dly > ioc_pkg::DLY_NONE) v.dly = ioc_pkg::DLY_PART;
         setc(v);
         rchk(ioc_pkg::CFG_OFS, {16'h0, v});
         wb(1'b0, ioc_pkg::STS_OFS, 32'h0);
         chk("status", {26'h0, flt, 1'b0, v.out_init_set, 1'b0, v.in_init_set, pin}
            & 32'h3b, rd & 32'h3b);
         for (int i = 0; i < 24; i++) begin
            lfsr = nxt(lfsr);
            {ext, ick, ock, cen, flt, fo} <= lfsr[5:0];
            @(negedge clk_i);
            chk("fab_a", c.in_route_a ? ea : pin, fa);
            chk("fab_b", c.in_route_b ? ea : pin, fb);
            chk("pad_o", c.out_reg ? oq_q : ob, pad_out);
            chk("pad_oe_n", flt, oe_n);
            @(posedge clk_i);
         end
      end
      close_out();
   end
endmodule
